/* hdl/fault_sup.sv */
// LED driver fault supervisor: flags, reactions, recovery timing.
// Assumes comparator inputs are asynchronous; host on Avalon-MM.
`timescale 1ns/1ps
module fault_sup
   import fault_sup_pkg::*;
#(
   parameter int unsigned GND_SHORT_CYCLES = GND_SHORT_CYC,
   parameter int unsigned BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_CYC,
   parameter int unsigned RETRY_CYCLES = RETRY_CYC,
   parameter int unsigned BOOST_UV_CYCLES = BOOST_UV_CYC
)
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic enable_i,
   input wire logic bright_nonzero_i,
   input wire logic init_done_i,
   input wire logic [3:0] string_short_i,
   input wire logic [3:0] string_normal_i,
   input wire logic [3:0] ground_short_i,
   input wire logic [3:0] below_headroom_i,
   input wire logic [3:0] above_headroom_hys_i,
   input wire logic [3:0] unused_mask_i,
   input wire logic [3:0] unused_not_grounded_i,
   input wire logic grouped_mode_i,
   input wire logic boost_at_min_i,
   input wire logic bus_cmd_open_i,
   input wire logic in_uv_i,
   input wire logic in_ov_i,
   input wire logic core_low_i,
   input wire logic in_oc_i,
   input wire logic pump_level_bad_i,
   input wire logic pump_parts_missing_i,
   input wire logic sync_lost_i,
   input wire logic boost_sync_input_i,
   input wire logic config_load_error_i,
   input wire logic boost_ov_low_i,
   input wire logic boost_ov_high_i,
   input wire logic feedback_uv_i,
   input wire logic string_res_bad_i,
   input wire logic mode_res_bad_i,
   input wire logic freq_res_bad_i,
   input wire logic [2:0] string_res_count_i,
   input wire logic [7:0] string_res_ma_i,
   input wire logic mode_res_phase_i,
   input wire logic [7:0] mode_res_addr_i,
   input wire logic [15:0] freq_res_boost_khz_i,
   input wire logic [15:0] freq_res_dim_hz_i,
   output logic [3:0] channel_pwm_en_o,
   output logic [3:0] channel_in_loop_o,
   output logic [3:0] test_current_en_o,
   output logic boost_en_o,
   output logic boost_switch_en_o,
   output logic power_fet_en_o,
   output logic pump_en_o,
   output logic bus_reset_o,
   output logic use_internal_clock_o,
   output logic spread_spectrum_o,
   output logic [2:0] ch_count_o,
   output logic [7:0] ch_ma_o,
   output logic phase_shift_o,
   output logic [7:0] bus_addr_o,
   output logic [15:0] boost_khz_o,
   output logic [15:0] dim_hz_o,
   output logic irq_o
);
   localparam int NSYNC = 37;
   initial
   begin
      if (GND_SHORT_CYCLES < 1 || GND_SHORT_CYCLES >= (1 << CNT_W) ||
          BUS_TIMEOUT_CYCLES >= (1 << CNT_W) ||
          RETRY_CYCLES >= (1 << CNT_W) || BOOST_UV_CYCLES >= (1 << CNT_W))
         $error("fault_sup: counts out of range");
   end

   // Two-flop synchronisers for every asynchronous comparator input
   logic [NSYNC-1:0] raw, s1_reg, s2_reg;
   assign raw = {string_short_i, string_normal_i, ground_short_i,
      below_headroom_i, above_headroom_hys_i, unused_not_grounded_i,
      boost_at_min_i, bus_cmd_open_i, in_uv_i, in_ov_i, core_low_i,
      in_oc_i, pump_level_bad_i, pump_parts_missing_i, sync_lost_i,
      boost_sync_input_i, boost_ov_low_i, boost_ov_high_i, feedback_uv_i};
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
      end
      else
      begin
         s1_reg <= raw;
         s2_reg <= s1_reg;
      end
   end
   logic [3:0] short_s, normal_s, gnd_s, below_hr_s, above_hys_s, unused_ng_s;
   logic min_s, open_s, uv_s, ov_s, core_s, oc_s, pl_s, pm_s, sl_s, sh_s;
   logic ovl_s, ovh_s, fuv_s;
   assign {short_s, normal_s, gnd_s, below_hr_s, above_hys_s, unused_ng_s,
      min_s, open_s, uv_s, ov_s, core_s, oc_s, pl_s, pm_s, sl_s, sh_s,
      ovl_s, ovh_s, fuv_s} = s2_reg;

   sup_state_t state_reg;
   logic [CNT_W-1:0] retry_cnt_reg, bus_cnt_reg, uv_cnt_reg;
   logic [3:0] ch_off_reg, ch_flag_reg;
   logic [15:0] str_reg;
   logic [6:0] sup_reg, bst_reg;
   logic recovery_req, standby_req, sync_armed_reg;
   logic [3:0] gnd_report;
   logic [NUM_CH*CNT_W-1:0] gcnt_reg;
   gnd_state_t [NUM_CH-1:0] gst_reg;

   // Host clear: write one to a bit to clear it, except the string short, ground and channel bits; a same-cycle set wins
   logic wr_str, wr_sup, wr_bst;
   // A write lands only on the edge that answers it, never twice
   logic wr_take;
   assign wr_take = avs_write_i && !avs_waitrequest_o;
   assign wr_str = wr_take && avs_address_i == ADDR_STRING_FAULT;
   assign wr_sup = wr_take && avs_address_i == ADDR_SUPPLY_FAULT;
   assign wr_bst = wr_take && avs_address_i == ADDR_BOOST_FAULT;

   function automatic logic sticky(input logic cur, input logic set,
      input logic clr);
      sticky = set | (cur & ~clr);
   endfunction : sticky

   // Shorted string detection
   logic [3:0] short_hit;
   logic any_normal;
   assign any_normal = |(normal_s & ~ch_off_reg & ~unused_mask_i);
   assign short_hit = ((short_s & {4{any_normal}})
      | (above_hys_s & {4{grouped_mode_i & min_s}}))
      & ~ch_off_reg & ~unused_mask_i
      & {4{state_reg == ST_NORMAL}};

   // Ground short per channel: watch, then test current, then judge
   logic gnd_watch_en;
   assign gnd_watch_en = state_reg == ST_SOFTSTART || state_reg == ST_NORMAL;
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : gen_gnd
         always_ff @(posedge clock_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               gst_reg[g] <= GS_WATCH;
               gcnt_reg[g*CNT_W +: CNT_W] <= '0;
            end
            else if (!gnd_watch_en || unused_mask_i[g])
            begin
               gst_reg[g] <= GS_WATCH;
               gcnt_reg[g*CNT_W +: CNT_W] <= '0;
            end
            else
            begin
               unique case (gst_reg[g])
                  GS_WATCH:
                  begin
                     if (!gnd_s[g])
                        gcnt_reg[g*CNT_W +: CNT_W] <= '0;
                     else if (gcnt_reg[g*CNT_W +: CNT_W] ==
                              CNT_W'(GND_SHORT_CYCLES - 1))
                     begin
                        gst_reg[g] <= GS_TEST;
                        gcnt_reg[g*CNT_W +: CNT_W] <= '0;
                     end
                     else
                        gcnt_reg[g*CNT_W +: CNT_W] <=
                           gcnt_reg[g*CNT_W +: CNT_W] + 1'b1;
                  end
                  GS_TEST:
                  begin
                     if (gcnt_reg[g*CNT_W +: CNT_W] ==
                         CNT_W'(TEST_CURRENT_CYC - 1))
                        gst_reg[g] <= GS_DONE;
                     else
                        gcnt_reg[g*CNT_W +: CNT_W] <=
                           gcnt_reg[g*CNT_W +: CNT_W] + 1'b1;
                  end
                  GS_DONE:
                  begin
                     gst_reg[g] <= GS_WATCH;
                     gcnt_reg[g*CNT_W +: CNT_W] <= '0;
                  end
               endcase
            end
         end
         assign gnd_report[g] = gst_reg[g] == GS_DONE && below_hr_s[g];
      end
   endgenerate

   // Bus timeout and feedback undervoltage timers
   logic bus_timeout, boost_oc_hit;
   assign bus_timeout = open_s &&
      bus_cnt_reg == CNT_W'(BUS_TIMEOUT_CYCLES - 1);
   assign boost_oc_hit = fuv_s && uv_cnt_reg == CNT_W'(BOOST_UV_CYCLES - 1) &&
      (state_reg == ST_SOFTSTART || state_reg == ST_NORMAL);
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         bus_cnt_reg <= '0;
      else if (!open_s || bus_timeout)
         bus_cnt_reg <= '0;
      else
         bus_cnt_reg <= bus_cnt_reg + 1'b1;
   end
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         uv_cnt_reg <= '0;
      else if (!fuv_s || boost_oc_hit)
         uv_cnt_reg <= '0;
      else
         uv_cnt_reg <= uv_cnt_reg + 1'b1;
   end
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         bus_reset_o <= 1'b0;
      else
         bus_reset_o <= bus_timeout;
   end

   // Sync loss only counts once a valid sync was running at enable
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         sync_armed_reg <= 1'b0;
      else if (!enable_i)
         sync_armed_reg <= 1'b0;
      else if (state_reg == ST_STANDBY && !sl_s)
         sync_armed_reg <= 1'b1;
   end
   logic sync_hit;
   assign sync_hit = sync_armed_reg && sl_s && !use_internal_clock_o;

   logic init_phase;
   assign init_phase = state_reg == ST_INIT && init_done_i;

   // Status flags
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         str_reg <= '0;
         ch_flag_reg <= '0;
      end
      else
      begin
         str_reg[SF_SUMMARY] <= sticky(str_reg[SF_SUMMARY],
            |short_hit | |gnd_report, wr_str && avs_writedata_i[SF_SUMMARY]);
         str_reg[SF_SHORT] <= str_reg[SF_SHORT] | |short_hit;
         str_reg[SF_GND] <= str_reg[SF_GND] | |gnd_report;
         str_reg[SF_INVALID] <= sticky(str_reg[SF_INVALID],
            init_phase && |(unused_ng_s & unused_mask_i),
            wr_str && avs_writedata_i[SF_INVALID]);
         str_reg[SF_BUS] <= sticky(str_reg[SF_BUS], bus_timeout,
            wr_str && avs_writedata_i[SF_BUS]);
         ch_flag_reg <= ch_flag_reg | short_hit | gnd_report;
         str_reg[SF_CH0 +: NUM_CH] <= ch_flag_reg;
      end
   end
   logic [6:0] sup_set, bst_set;
   assign sup_set = {config_load_error_i && init_phase,
      pm_s, pl_s | pm_s,
      oc_s, core_s, ov_s, uv_s};
   assign bst_set = {freq_res_bad_i && init_phase, mode_res_bad_i && init_phase,
      string_res_bad_i && init_phase, boost_oc_hit, ovh_s, ovl_s, sync_hit};
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sup_reg <= '0;
         bst_reg <= '0;
      end
      else
      begin
         for (int i = 0; i < 7; i++)
         begin
            sup_reg[i] <= sticky(sup_reg[i], sup_set[i],
               wr_sup && avs_writedata_i[i]);
            bst_reg[i] <= sticky(bst_reg[i], bst_set[i],
               wr_bst && avs_writedata_i[i]);
         end
      end
   end

   // Interrupt: all classes except boost overvoltage low and resistor faults
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         irq_o <= 1'b0;
      else
         irq_o <= str_reg[SF_SUMMARY] | str_reg[SF_INVALID] | str_reg[SF_BUS]
            | |sup_reg | bst_reg[BF_SYNC] | bst_reg[BF_OV_HIGH]
            | bst_reg[BF_OC];
   end

   // Supervisor state machine
   assign recovery_req = |gnd_report | oc_s | pl_s | ovh_s | boost_oc_hit;
   assign standby_req = uv_s | ov_s | core_s | !enable_i;
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= ST_INIT;
         retry_cnt_reg <= '0;
      end
      else
      begin
         unique case (state_reg)
            ST_INIT:
               if (init_done_i)
                  state_reg <= ST_STANDBY;
            ST_STANDBY:
               if (!standby_req && bright_nonzero_i)
                  state_reg <= ST_SOFTSTART;
            ST_SOFTSTART, ST_NORMAL:
            begin
               if (recovery_req)
               begin
                  state_reg <= ST_RECOVERY;
                  retry_cnt_reg <= '0;
               end
               else if (standby_req)
                  state_reg <= ST_STANDBY;
               else
                  state_reg <= ST_NORMAL;
            end
            ST_RECOVERY:
            begin
               // Overvoltage high also waits for the output to fall
               if (retry_cnt_reg != CNT_W'(RETRY_CYCLES - 1))
                  retry_cnt_reg <= retry_cnt_reg + 1'b1;
               else if (!ovh_s && enable_i && bright_nonzero_i)
                  state_reg <= ST_STANDBY;
            end
         endcase
      end
   end

   // Pump stays off once parts are missing; a status clear must not revive it
   logic pump_off_reg;
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         pump_off_reg <= 1'b0;
      else if (pm_s)
         pump_off_reg <= 1'b1;
   end

   // Channel disables stay until the next power cycle
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ch_off_reg <= '0;
      else
         ch_off_reg <= ch_off_reg | short_hit;
   end
   logic run;
   assign run = state_reg == ST_NORMAL;
   logic [3:0] testing;
   always_comb
   begin
      for (int i = 0; i < NUM_CH; i++)
         testing[i] = gst_reg[i] != GS_WATCH;
   end
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         channel_pwm_en_o <= '0;
         channel_in_loop_o <= '0;
         test_current_en_o <= '0;
         boost_en_o <= 1'b0;
         boost_switch_en_o <= 1'b0;
         power_fet_en_o <= 1'b0;
         pump_en_o <= 1'b0;
      end
      else
      begin
         channel_pwm_en_o <= {4{run && bright_nonzero_i}} & ~ch_off_reg
            & ~testing & ~unused_mask_i;
         channel_in_loop_o <= ~ch_off_reg & ~unused_mask_i;
         test_current_en_o <= {4{gnd_watch_en}}
            & (testing & ~{4{1'b0}}) & {gst_reg[3] == GS_TEST,
            gst_reg[2] == GS_TEST, gst_reg[1] == GS_TEST,
            gst_reg[0] == GS_TEST};
         boost_en_o <= gnd_watch_en;
         boost_switch_en_o <= gnd_watch_en && !ovl_s;
         power_fet_en_o <= gnd_watch_en;
         pump_en_o <= state_reg != ST_INIT && !pump_off_reg
            && !pm_s;
      end
   end

   // Sync fallback
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         use_internal_clock_o <= 1'b0;
         spread_spectrum_o <= 1'b0;
      end
      else if (sync_hit)
      begin
         use_internal_clock_o <= 1'b1;
         spread_spectrum_o <= sh_s;
      end
   end

   // Resistor-derived configuration, latched once at initialization
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ch_count_o <= DEFAULT_CH_COUNT;
         ch_ma_o <= DEFAULT_CH_MA;
         phase_shift_o <= 1'b1;
         bus_addr_o <= DEFAULT_BUS_ADDR;
         boost_khz_o <= DEFAULT_BOOST_KHZ;
         dim_hz_o <= DEFAULT_DIM_HZ;
      end
      else if (init_phase)
      begin
         ch_count_o <= string_res_bad_i ? DEFAULT_CH_COUNT
            : string_res_count_i;
         ch_ma_o <= string_res_bad_i ? DEFAULT_CH_MA : string_res_ma_i;
         phase_shift_o <= mode_res_bad_i | mode_res_phase_i;
         bus_addr_o <= mode_res_bad_i ? DEFAULT_BUS_ADDR : mode_res_addr_i;
         boost_khz_o <= freq_res_bad_i ? DEFAULT_BOOST_KHZ
            : freq_res_boost_khz_i;
         dim_hz_o <= freq_res_bad_i ? DEFAULT_DIM_HZ : freq_res_dim_hz_i;
      end
   end

   // Avalon slave: one wait state so read data stands when the answer comes;
   // unmapped reads return zero
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         avs_readdata_o <= '0;
         avs_waitrequest_o <= 1'b1;
      end
      else
      begin
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) &&
            avs_waitrequest_o);
         unique case (avs_address_i)
            ADDR_STRING_FAULT: avs_readdata_o <= {16'h0000, str_reg};
            ADDR_SUPPLY_FAULT: avs_readdata_o <= {25'h0, sup_reg};
            ADDR_BOOST_FAULT: avs_readdata_o <= {25'h0, bst_reg};
            ADDR_CONFIG: avs_readdata_o <= {state_reg, 5'h00, ch_off_reg,
               4'h0, use_internal_clock_o, 3'h0, bus_addr_o, 4'h0};
            default: avs_readdata_o <= '0;
         endcase
      end
   end
endmodule : fault_sup

/* hdl/fault_sup_pkg.sv */
// Constants for the LED driver fault supervisor.
// Assumes a single 25 MHz clock; all timing derives from CLK_HZ.
package fault_sup_pkg;
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned GND_SHORT_MS = 20;
   localparam int unsigned TEST_CURRENT_US = 300;
   localparam int unsigned BUS_TIMEOUT_MS = 500;
   localparam int unsigned RETRY_MS = 100;
   localparam int unsigned BOOST_UV_MS = 110;
   localparam int unsigned GND_SHORT_CYC = GND_SHORT_MS * (CLK_HZ / 1000);
   localparam int unsigned TEST_CURRENT_CYC =
      TEST_CURRENT_US * (CLK_HZ / 1000000);
   localparam int unsigned BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int unsigned RETRY_CYC = RETRY_MS * (CLK_HZ / 1000);
   localparam int unsigned BOOST_UV_CYC = BOOST_UV_MS * (CLK_HZ / 1000);
   localparam int CNT_W = 24;
   localparam int NUM_CH = 4;
   // Avalon register word offsets (byte addresses)
   localparam logic [3:0] ADDR_STRING_FAULT = 4'h0;
   localparam logic [3:0] ADDR_SUPPLY_FAULT = 4'h4;
   localparam logic [3:0] ADDR_BOOST_FAULT = 4'h8;
   localparam logic [3:0] ADDR_CONFIG = 4'hc;
   // String fault register bits
   localparam int SF_SUMMARY = 0;
   localparam int SF_SHORT = 1;
   localparam int SF_GND = 2;
   localparam int SF_INVALID = 3;
   localparam int SF_BUS = 4;
   localparam int SF_CH0 = 8;
   // Supply fault register bits
   localparam int SP_IN_UV = 0;
   localparam int SP_IN_OV = 1;
   localparam int SP_CORE_LOW = 2;
   localparam int SP_IN_OC = 3;
   localparam int SP_PUMP_LVL = 4;
   localparam int SP_PUMP_MISS = 5;
   localparam int SP_CRC = 6;
   // Boost fault register bits
   localparam int BF_SYNC = 0;
   localparam int BF_OV_LOW = 1;
   localparam int BF_OV_HIGH = 2;
   localparam int BF_OC = 3;
   localparam int BF_STR_RES = 4;
   localparam int BF_MODE_RES = 5;
   localparam int BF_FREQ_RES = 6;
   localparam logic [7:0] DEFAULT_BUS_ADDR = 8'h3a;
   localparam logic [2:0] DEFAULT_CH_COUNT = 3'h4;
   localparam logic [7:0] DEFAULT_CH_MA = 8'hc8;
   localparam logic [15:0] DEFAULT_BOOST_KHZ = 16'h0190;
   localparam logic [15:0] DEFAULT_DIM_HZ = 16'h0131;
   typedef enum logic [2:0] {
      ST_INIT, ST_STANDBY, ST_SOFTSTART, ST_NORMAL, ST_RECOVERY
   } sup_state_t;
   typedef enum logic [1:0] {GS_WATCH, GS_TEST, GS_DONE} gnd_state_t;
endpackage : fault_sup_pkg

/* tb/fault_sup_monitor.sv */
// Port checker for the fault supervisor.
// Assumes one clock domain; bound into every fault_sup below.
`timescale 1ns/1ps
module fault_sup_monitor (
   input wire logic clock_i, rst_n_i, avs_write_i, init_done_i, in_uv_i,
   input wire logic in_oc_i, boost_ov_low_i, pump_parts_missing_i, irq_o,
   input wire logic bus_reset_o, boost_en_o, boost_switch_en_o,
   input wire logic power_fet_en_o, pump_en_o,
   input wire logic [3:0] test_current_en_o, channel_pwm_en_o,
   input wire logic [2:0] ch_count_o,
   input wire logic [7:0] bus_addr_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   chk_test_isolated: assert property (|test_current_en_o |->
      (test_current_en_o & channel_pwm_en_o) == 4'h0) else $error("Pwm on");
   chk_ovlow_halt: assert property (boost_ov_low_i [*4] |->
      !boost_switch_en_o) else $error("Boost still switching");
   chk_uv_standby: assert property (in_uv_i [*5] |->
      !power_fet_en_o && !boost_en_o) else $error("Not in standby");
   chk_busrst_pulse: assert property (bus_reset_o |=>
      !bus_reset_o) else $error("Bus reset too long");
   chk_cfg_kept: assert property ($past(init_done_i, 2) && init_done_i |->
      $stable(ch_count_o) && $stable(bus_addr_o)) else $error("Config moved");
   chk_irq_cleared: assert property ($fell(irq_o) |->
      $past(avs_write_i) || $past(avs_write_i, 2)) else $error("Irq fell");
   chk_pump_off: assert property (pump_parts_missing_i [*4] |->
      !pump_en_o) else $error("Pump still on");
   chk_oc_off: assert property ($rose(in_oc_i) |->
      ##[1:6] !power_fet_en_o) else $error("Power fet on");
endmodule : fault_sup_monitor
bind fault_sup fault_sup_monitor u_mon (.*);

/* tb/fault_sup_partner.sv */
// Boost stage model: high overvoltage that decays once switching stops.
// Assumes the bench raises ov_cmd_i to force the overvoltage.
`timescale 1ns/1ps
module fault_sup_partner (
   input wire logic clock_i,
   input wire logic switch_en_i,
   input wire logic ov_cmd_i,
   output logic ov_high_o
);
   logic [3:0] idle_reg = 4'h8;
   // Output only falls after eight quiet cycles, so a slow stage is seen
   always_ff @(posedge clock_i)
   begin
      if (ov_cmd_i)
         idle_reg <= 4'h0;
      else if (!switch_en_i && idle_reg != 4'h8)
         idle_reg <= idle_reg + 4'h1;
   end
   assign ov_high_o = ov_cmd_i || idle_reg != 4'h8;
endmodule : fault_sup_partner

/* tb/fault_sup_tb.sv */
// Bench for fault_sup: defaults, flag table, string and ground shorts.
// Assumes shortened counts below and the bound port checker.
`timescale 1ns/1ps
module fault_sup_tb;
   import fault_sup_pkg::*;
   logic clock_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0;
   logic enable_i = 0, bright_nonzero_i = 0, init_done_i = 0, resb = 1;
   logic [3:0] avs_address_i = 0, string_short_i = 0, string_normal_i = 0;
   logic [3:0] ground_short_i = 0, below_headroom_i = 0, unused_mask_i = 8;
   logic [3:0] unused_not_grounded_i = 8, above_headroom_hys_i;
   logic [31:0] avs_writedata_i = 0, avs_readdata_o, q;
   logic avs_waitrequest_o, grouped_mode_i, boost_at_min_i, bus_cmd_open_i;
   logic in_uv_i, in_ov_i, core_low_i, in_oc_i, pump_level_bad_i;
   logic pump_parts_missing_i, sync_lost_i, boost_sync_input_i;
   logic config_load_error_i, boost_ov_low_i, boost_ov_high_i;
   logic feedback_uv_i, string_res_bad_i, mode_res_bad_i, freq_res_bad_i;
   logic mode_res_phase_i, phase_shift_o, boost_en_o, boost_switch_en_o;
   logic power_fet_en_o, pump_en_o, bus_reset_o, irq_o;
   logic use_internal_clock_o, spread_spectrum_o;
   logic [2:0] string_res_count_i, ch_count_o;
   logic [7:0] string_res_ma_i, mode_res_addr_i, ch_ma_o, bus_addr_o;
   logic [7:0] rv = 8'h11;
   logic [15:0] freq_res_boost_khz_i, freq_res_dim_hz_i, boost_khz_o, dim_hz_o;
   logic [3:0] channel_pwm_en_o, channel_in_loop_o, test_current_en_o;
   logic [11:0] f = 12'h040;
   logic [11:0] ri = 12'heff;
   int ra [12] = '{4, 4, 4, 4, 4, 4, 4, 8, 8, 8, 0, 8};
   int rb [12] = '{0, 1, 2, 3, 4, 5, 6, 0, 1, 2, 4, 3};
   int errors = 0, tests_run = 0;
   assign {feedback_uv_i, bus_cmd_open_i, boost_ov_low_i, sync_lost_i,
      config_load_error_i, pump_parts_missing_i, pump_level_bad_i, in_oc_i,
      core_low_i, in_ov_i, in_uv_i} = {f[11:10], f[8:0]};
   // Sync pin held high, so a lost sync must turn spreading on
   logic [7:0] tie = 8'h20;
   assign {grouped_mode_i, boost_at_min_i, boost_sync_input_i,
      mode_res_phase_i, above_headroom_hys_i} = tie;
   assign {string_res_bad_i, mode_res_bad_i, freq_res_bad_i} = {3{resb}};
   assign string_res_count_i = rv[2:0];
   assign {string_res_ma_i, mode_res_addr_i} = {rv, rv};
   assign {freq_res_boost_khz_i, freq_res_dim_hz_i} = {4{rv}};
   always #20 clock_i = ~clock_i;
   fault_sup #(.GND_SHORT_CYCLES(20), .BUS_TIMEOUT_CYCLES(50),
      .RETRY_CYCLES(30), .BOOST_UV_CYCLES(40)) u_dut (.*);
   fault_sup_partner u_stage (.clock_i(clock_i),
      .switch_en_i(boost_switch_en_o), .ov_cmd_i(f[9]),
      .ov_high_o(boost_ov_high_i));
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : cmp
   // Request stands until waitrequest is seen low; read data is taken there
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= !w;
      @(posedge clock_i);
      while (avs_waitrequest_o !== 1'b0)
         @(posedge clock_i);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clock_i);
   endtask : bus
   task automatic end_sim();
      if (errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_sim
   initial
   begin
      repeat (16) @(posedge clock_i);
      rst_n_i <= 1'b1;
      enable_i <= 1'b1;
      bright_nonzero_i <= 1'b1;
      // Let the pin synchronisers fill before the init-time checks
      repeat (4) @(posedge clock_i);
      init_done_i <= 1'b1;
      repeat (6) @(posedge clock_i);
      rv <= 8'h22;
      resb <= 1'b0;
      f[6] <= 1'b0;
      unused_mask_i <= 4'h0;
      cmp({ch_count_o, ch_ma_o}, {DEFAULT_CH_COUNT, DEFAULT_CH_MA});
      cmp({phase_shift_o, bus_addr_o}, {1'b1, DEFAULT_BUS_ADDR});
      cmp({boost_khz_o, dim_hz_o}, {DEFAULT_BOOST_KHZ, DEFAULT_DIM_HZ});
      bus(1'b0, 4'h8, 32'h0);
      cmp(q[6:4], 3'h7);
      bus(1'b0, 4'h4, 32'h0);
      cmp(q[6], 1'b1);
      bus(1'b0, 4'h0, 32'h0);
      cmp({q[3], irq_o}, 2'h3);
      bus(1'b1, 4'h0, 32'hffffffff);
      bus(1'b1, 4'h4, 32'hffffffff);
      bus(1'b1, 4'h8, 32'hffffffff);
      for (int i = 0; i < 12; i++)
      begin
         if (i == 6)
            continue;
         f[i] <= 1'b1;
         repeat (60) @(posedge clock_i);
         bus(1'b0, ra[i][3:0], 32'h0);
         cmp(q[rb[i]], 1'b1);
         cmp(irq_o, ri[i]);
         f[i] <= 1'b0;
         repeat (60) @(posedge clock_i);
         bus(1'b1, ra[i][3:0], 32'hffffffff);
         repeat (4) @(posedge clock_i);
         cmp(irq_o, 1'b0);
      end
      repeat (200) @(posedge clock_i);
      cmp(channel_pwm_en_o, 4'hf);
      cmp({use_internal_clock_o, spread_spectrum_o}, 2'h3);
      string_normal_i <= 4'he;
      string_short_i <= 4'h1;
      repeat (10) @(posedge clock_i);
      cmp({channel_in_loop_o[0], channel_pwm_en_o[0], irq_o}, 3'h1);
      string_short_i <= 4'h0;
      bus(1'b0, 4'h0, 32'h0);
      cmp(q[11:0], 12'h103);
      bus(1'b1, 4'h0, 32'hffffffff);
      bus(1'b0, 4'h0, 32'h0);
      cmp(q[11:0], 12'h102);
      ground_short_i <= 4'h2;
      below_headroom_i <= 4'h2;
      tie <= 8'he4;
      repeat (40) @(posedge clock_i);
      cmp(test_current_en_o, 4'h2);
      cmp(channel_in_loop_o, 4'ha);
      repeat (7560) @(posedge clock_i);
      ground_short_i <= 4'h0;
      bus(1'b0, 4'h0, 32'h0);
      cmp(q[11:0], 12'h707);
      end_sim();
   end
   initial
   begin
      repeat (20000) @(posedge clock_i);
      errors++;
      end_sim();
   end
endmodule : fault_sup_tb
